// ### logic/sdm_data_mem.v
// Overview of operation
// R1 - Every location is one byte wide
// R2 - Offsets below 80H special, above general
// R3 - Two sectors, 128 general bytes each
// R4 - No bank select register exists
// R5 - Ports A and B take sector from pointer
// R6 - Ports A and B take offset from pointer
// R7 - Extended address: bit 8 sector, low byte offset
// R8 - Direct extended access reaches every sector
// R9 - Unassigned special locations read zero
// R10 - Some special registers are read-only
// R11 - General bytes support byte and bit writes
// R12 - Port access redirects through its pointer
// R13 - Port zero reaches sector zero only
// R14 - Ports A and B reach any sector
// R15 - Port via pointer reads zero, ignores write
// R16 - Ports and pointers at fixed sector-0 offsets
// R17 - Pointers are ordinary read/write registers
// R18 - Sector values above one use bit 0
//
// Core access: one request per clock on req. Reads answer on rdata_q the
// next cycle. A write carries wr=1; bit operations use bit_op with bit_sel
// and bit_val, done as a read-modify-write within one cycle.
// Special registers other than the pointers live in their own blocks: this
// module hands them out on sfr_* and takes their data back on sfr_rdata.
`include "sdm_consts.vh"
module sdm_data_mem #(
   parameter SECTORS = 2
) (
   clk,
   rst,
   req,
   mode,
   wr,
   addr,
   wdata,
   bit_op,
   bit_sel,
   bit_val,
   sfr_rdata,
   sfr_present,
   sfr_ro,
   rdata_q,
   rvalid_q,
   sfr_we_q,
   sfr_addr_q,
   sfr_wdata_q
);
   input wire clk;
   input wire rst;
   input wire req;
   input wire [1:0] mode;
   input wire wr;
   input wire [8:0] addr;
   input wire [7:0] wdata;
   input wire bit_op;
   input wire [2:0] bit_sel;
   input wire bit_val;
   input wire [7:0] sfr_rdata;
   input wire sfr_present;
   input wire sfr_ro;
   output reg [7:0] rdata_q;
   output reg rvalid_q;
   output reg sfr_we_q;
   output reg [7:0] sfr_addr_q;
   output reg [7:0] sfr_wdata_q;

   localparam RAW = 8;

   wire [7:0] ptr0;
   wire [7:0] ptra_lo;
   wire [7:0] ptra_sec;
   wire [7:0] ptrb_lo;
   wire [7:0] ptrb_sec;
   wire [7:0] ram_rdata;

   // Which pointer byte, if any, an offset in sector 0 names
   function [4:0] ptr_sel;
      input sec;
      input [7:0] ofs;
      begin
         ptr_sel = 5'h00;
         if (!sec) begin
            case (ofs)
               `SDM_OFS_PTR0: ptr_sel = 5'h01;
               `SDM_OFS_PTRA_LO: ptr_sel = 5'h02;
               `SDM_OFS_PTRA_SEC: ptr_sel = 5'h04;
               `SDM_OFS_PTRB_LO: ptr_sel = 5'h08;
               `SDM_OFS_PTRB_SEC: ptr_sel = 5'h10;
               default: ptr_sel = 5'h00;
            endcase
         end
      end
   endfunction

   // Is the offset one of the three ports in sector 0
   function is_port;
      input sec;
      input [7:0] ofs;
      begin
         is_port = !sec && (ofs == `SDM_OFS_PORT0 || ofs == `SDM_OFS_PORTA ||
            ofs == `SDM_OFS_PORTB); // [R16]
      end
   endfunction

   reg dsec; // first-level sector
   reg [7:0] dofs;
   reg esec; // effective sector after redirection
   reg [7:0] eofs;
   reg via_port;
   reg nested;

   // Sector comes only from the extended address or a pointer [R4]
   always @* begin
      if (mode == `SDM_MODE_EXT) begin
         dsec = addr[`SDM_XSEC_BIT]; // [R7] [R8] [R18]
      end else begin
         dsec = 1'b0;
      end
      dofs = addr[7:0]; // [R7]
      esec = dsec;
      eofs = dofs;
      via_port = 1'b0;
      if (!dsec && dofs == `SDM_OFS_PORT0) begin
         via_port = 1'b1;
         esec = 1'b0; // [R13]
         eofs = ptr0; // [R12]
      end else if (!dsec && dofs == `SDM_OFS_PORTA) begin
         via_port = 1'b1;
         esec = ptra_sec[0]; // [R5] [R14] [R18]
         eofs = ptra_lo; // [R6]
      end else if (!dsec && dofs == `SDM_OFS_PORTB) begin
         via_port = 1'b1;
         esec = ptrb_sec[0]; // [R5] [R14] [R18]
         eofs = ptrb_lo; // [R6]
      end
      // A pointer aimed back at a port reads zero and drops writes
      nested = via_port && is_port(esec, eofs); // [R15]
   end

   wire is_gp = eofs[`SDM_GP_BIT]; // [R2]
   wire [4:0] psel = ptr_sel(esec, eofs);
   wire is_ptr = |psel;
   wire sfr_hit = !is_gp && !is_ptr && !is_port(esec, eofs) && !esec;
   wire [RAW-1:0] ram_addr = {esec, eofs[6:0]}; // [R3]

   reg [7:0] cur;
   reg [7:0] newv;
   always @* begin
      cur = `SDM_READ_ZERO; // [R9]
      if (nested || is_port(esec, eofs)) begin
         cur = `SDM_READ_ZERO; // [R15]
      end else if (is_gp) begin
         cur = ram_rdata;
      end else if (psel[0]) begin
         cur = ptr0;
      end else if (psel[1]) begin
         cur = ptra_lo;
      end else if (psel[2]) begin
         cur = ptra_sec;
      end else if (psel[3]) begin
         cur = ptrb_lo;
      end else if (psel[4]) begin
         cur = ptrb_sec;
      end else if (sfr_hit && sfr_present) begin
         cur = sfr_rdata;
      end
      newv = wdata;
      if (bit_op) begin
         newv = cur;
         newv[bit_sel] = bit_val; // [R11]
      end
   end

   wire do_wr = req && wr && !nested && !is_port(esec, eofs);

   sdm_gp_ram #(
      .SECTORS(SECTORS),
      .AW(RAW)
   ) u_ram (
      .clk(clk),
      .we(do_wr && is_gp),
      .waddr(ram_addr),
      .wdata(newv),
      .raddr(ram_addr),
      .rdata(ram_rdata)
   );

   sdm_ptr_regs u_ptr (
      .clk(clk),
      .rst(rst),
      .we(do_wr),
      .wsel(psel),
      .wdata(newv),
      .ptr0(ptr0),
      .ptra_lo(ptra_lo),
      .ptra_sec(ptra_sec),
      .ptrb_lo(ptrb_lo),
      .ptrb_sec(ptrb_sec)
   );

   // One-byte data path throughout [R1]
   always @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         sfr_we_q <= 1'b0;
         sfr_addr_q <= 8'h00;
         sfr_wdata_q <= 8'h00;
      end else begin
         rvalid_q <= req && !wr;
         if (req && !wr) begin
            rdata_q <= cur;
         end
         // Read-only or absent special registers never see a write [R10]
         sfr_we_q <= do_wr && sfr_hit && sfr_present && !sfr_ro;
         if (req) begin
            sfr_addr_q <= eofs;
            sfr_wdata_q <= newv;
         end
      end
   end
endmodule // sdm_data_mem

// ### logic/sdm_consts.vh
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH
// Special area offsets inside sector 0
`define SDM_OFS_PORT0 8'h00
`define SDM_OFS_PTR0 8'h01
`define SDM_OFS_PORTA 8'h02
`define SDM_OFS_PTRA_LO 8'h03
`define SDM_OFS_PTRA_SEC 8'h04
`define SDM_OFS_PORTB 8'h0c
`define SDM_OFS_PTRB_LO 8'h0d
`define SDM_OFS_PTRB_SEC 8'h0e
// Boundary between special and general areas: bit 7 of the offset
`define SDM_GP_BIT 7
// Extended address: bit 8 picks the sector
`define SDM_XSEC_BIT 8
// Reset value of the pointer bytes
`define SDM_PTR_RST 8'h00
// Value returned by unassigned special locations and ports
`define SDM_READ_ZERO 8'h00
// Access modes
`define SDM_MODE_STD 2'h0
`define SDM_MODE_EXT 2'h1
`endif

// ### logic/sdm_gp_ram.v
`include "sdm_consts.vh"
// General-purpose RAM: upper half of each sector, one byte per location
module sdm_gp_ram #(
   parameter SECTORS = 2,
   parameter AW = 8
) (
   clk,
   we,
   waddr,
   wdata,
   raddr,
   rdata
);
   input wire clk;
   input wire we;
   input wire [AW-1:0] waddr;
   input wire [7:0] wdata;
   input wire [AW-1:0] raddr;
   output wire [7:0] rdata;
   reg [7:0] mem [0:SECTORS*128-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata; // [R11]
      end
   end
   // Asynchronous read so the core sees the byte in the same cycle
   assign rdata = mem[raddr];
endmodule // sdm_gp_ram

// ### logic/sdm_ptr_regs.v
`include "sdm_consts.vh"
// The five pointer bytes; ordinary read/write registers in sector 0
module sdm_ptr_regs (
   clk,
   rst,
   we,
   wsel,
   wdata,
   ptr0,
   ptra_lo,
   ptra_sec,
   ptrb_lo,
   ptrb_sec
);
   input wire clk;
   input wire rst;
   input wire we;
   input wire [4:0] wsel;
   input wire [7:0] wdata;
   output wire [7:0] ptr0;
   output wire [7:0] ptra_lo;
   output wire [7:0] ptra_sec;
   output wire [7:0] ptrb_lo;
   output wire [7:0] ptrb_sec;
   reg [7:0] regs_q [0:4];
   genvar g;

   generate
      for (g = 0; g < 5; g = g + 1) begin : g_ptr
         always @(posedge clk) begin
            if (rst) begin
               regs_q[g] <= `SDM_PTR_RST;
            end else if (we && wsel[g]) begin
               regs_q[g] <= wdata; // [R17]
            end
         end
      end
   endgenerate

   assign ptr0 = regs_q[0];
   assign ptra_lo = regs_q[1];
   assign ptra_sec = regs_q[2];
   assign ptrb_lo = regs_q[3];
   assign ptrb_sec = regs_q[4];
endmodule // sdm_ptr_regs

// ### tb/sdm_sfr_model.sv
// Stands in for the special registers that live outside the memory block
module sdm_sfr_model #(
   parameter logic [7:0] RO_VAL = 8'h5a
) (
   input wire clk,
   input wire rst,
   input wire [7:0] ofs,
   input wire we,
   input wire [7:0] waddr,
   input wire [7:0] wdata,
   output wire [7:0] rdata,
   output wire present,
   output wire ro
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rw_q;
   assign present = ofs == 8'h10 || ofs == 8'h11;
   assign ro = ofs == 8'h11;
   // Junk off the decoded places, so a block that passes it on is caught
   assign rdata = ofs == 8'h10 ? rw_q : (ro ? RO_VAL : ~rw_q);
   always @(posedge clk) begin
      if (rst)
         rw_q <= 8'h00;
      else if (we && waddr == 8'h10)
         rw_q <= wdata;
   end
endmodule // sdm_sfr_model

// ### tb/sdm_data_mem_checker.sv
module sdm_data_mem_checker (
   input wire clk,
   input wire rst,
   input wire req,
   input wire [1:0] mode,
   input wire wr,
   input wire [8:0] addr,
   input wire [7:0] wdata,
   input wire bit_op,
   input wire [7:0] sfr_rdata,
   input wire sfr_present,
   input wire sfr_ro,
   input wire [7:0] rdata_q,
   input wire rvalid_q,
   input wire sfr_we_q,
   input wire [7:0] sfr_addr_q,
   input wire [7:0] sfr_wdata_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire sfr_hit = !addr[7] && addr[7:0] > 8'h0e && mode == 2'h0;
   a_read_answer: assert property (req && !wr |=> rvalid_q)
      else $error("read not answered");
   a_write_silent: assert property (req && wr |=> !rvalid_q && $stable(rdata_q))
      else $error("write disturbed read data");
   a_unused_zero: assert property (req && !wr && sfr_hit && !sfr_present |=> !rdata_q)
      else $error("unused place not zero");
   a_sfr_read: assert property (req && !wr && sfr_hit && sfr_present
      |=> rdata_q == $past(sfr_rdata))
      else $error("special read data wrong");
   a_ro_dropped: assert property (req && wr && sfr_hit && sfr_ro |=> !sfr_we_q)
      else $error("read-only write forwarded");
   a_sfr_forward: assert property (req && wr && !bit_op && sfr_hit && sfr_present && !sfr_ro
      |=> sfr_we_q && sfr_addr_q == $past(addr[7:0]) && sfr_wdata_q == $past(wdata))
      else $error("special write not forwarded");
   a_gp_no_strobe: assert property (req && addr[7] |=> !sfr_we_q)
      else $error("general access strobed");
   a_sec1_low_zero: assert property (req && !wr && mode == 2'h1 && addr[8] && !addr[7]
      |=> rdata_q == 8'h00)
      else $error("sector 1 special not zero");
endmodule // sdm_data_mem_checker
bind sdm_data_mem sdm_data_mem_checker chk (.clk, .rst, .req, .mode, .wr, .addr, .wdata,
   .bit_op, .sfr_rdata, .sfr_present, .sfr_ro, .rdata_q, .rvalid_q, .sfr_we_q, .sfr_addr_q,
   .sfr_wdata_q);

// ### tb/sdm_data_mem_tb.sv
module sdm_data_mem_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, req = 0, wr = 0, bit_op = 0, bit_val = 0;
   logic [1:0] mode = 0;
   logic [8:0] addr = 0;
   logic [7:0] wdata = 0;
   logic [2:0] bit_sel = 0;
   wire [7:0] sfr_rdata, rdata_q, sfr_addr_q, sfr_wdata_q;
   wire sfr_present, sfr_ro, rvalid_q, sfr_we_q;
   int n_errors = 0, samples_checked = 0;
   logic [7:0] ptrs [5] = '{8'h01, 8'h03, 8'h04, 8'h0d, 8'h0e};
   logic [8:0] xa [4] = '{9'h080, 9'h180, 9'h1ff, 9'h0ff};
   sdm_data_mem dut (.clk, .rst, .req, .mode, .wr, .addr, .wdata, .bit_op, .bit_sel, .bit_val,
      .sfr_rdata, .sfr_present, .sfr_ro, .rdata_q, .rvalid_q, .sfr_we_q, .sfr_addr_q,
      .sfr_wdata_q);
   sdm_sfr_model sfr (.clk, .rst, .ofs(addr[7:0]), .we(sfr_we_q), .waddr(sfr_addr_q),
      .wdata(sfr_wdata_q), .rdata(sfr_rdata), .present(sfr_present), .ro(sfr_ro));
   initial forever #12.5 clk = ~clk;
   task tally_and_finish;
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task acc(input logic [1:0] m, input logic w, input logic [8:0] a, input logic [7:0] d,
      input logic b = 0, input logic [2:0] s = 0, input logic v = 0);
      @(posedge clk);
      req <= 1;
      mode <= m;
      wr <= w;
      addr <= a;
      wdata <= d;
      bit_op <= b;
      bit_sel <= s;
      bit_val <= v;
      @(posedge clk);
      req <= 0;
      #1;
   endtask
   task rd(input logic [1:0] m, input logic [8:0] a, input logic [7:0] e);
      acc(m, 0, a, 8'h00);
      chk("rvalid_q", 8'h01, {7'h0, rvalid_q});
      chk("rdata_q", e, rdata_q);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 5; i++) begin
         rd(0, {1'b0, ptrs[i]}, 8'h00);
         acc(0, 1, {1'b0, ptrs[i]}, 8'(8'h30 + i));
         rd(0, {1'b0, ptrs[i]}, 8'(8'h30 + i));
      end
      for (int i = 0; i < 4; i++)
         acc(1, 1, xa[i], 8'(8'h11 * (i + 1)));
      for (int i = 0; i < 4; i++)
         rd(1, xa[i], 8'(8'h11 * (i + 1)));
      rd(0, 9'h180, 8'h11);
      acc(0, 1, 9'h001, 8'h80);
      rd(0, 9'h000, 8'h11);
      acc(0, 1, 9'h000, 8'h55);
      rd(1, 9'h080, 8'h55);
      acc(0, 1, 9'h004, 8'h01);
      acc(0, 1, 9'h003, 8'hf0);
      acc(0, 1, 9'h002, 8'h66);
      rd(1, 9'h1f0, 8'h66);
      acc(0, 1, 9'h004, 8'h03);
      rd(0, 9'h002, 8'h66);
      acc(0, 1, 9'h00e, 8'h00);
      acc(0, 1, 9'h00d, 8'hff);
      rd(0, 9'h00c, 8'h44);
      acc(0, 1, 9'h001, 8'h00);
      acc(0, 1, 9'h000, 8'h77);
      rd(0, 9'h000, 8'h00);
      rd(0, 9'h001, 8'h00);
      rd(0, 9'h00b, 8'h00);
      rd(0, 9'h020, 8'h00);
      acc(1, 1, 9'h105, 8'h99);
      rd(1, 9'h105, 8'h00);
      acc(0, 1, 9'h010, 8'ha5);
      rd(0, 9'h010, 8'ha5);
      acc(0, 1, 9'h011, 8'h00);
      rd(0, 9'h011, 8'h5a);
      acc(1, 1, 9'h180, 8'h00, 1, 3'h7, 1);
      rd(1, 9'h180, 8'ha2);
      acc(1, 1, 9'h180, 8'hff, 1, 3'h1, 0);
      rd(1, 9'h180, 8'ha0);
      tally_and_finish;
   end
   // Whole run is near 120 cycles; over sixteen times that means a hang
   initial begin
      repeat (2000) @(posedge clk);
      n_errors++;
      tally_and_finish;
   end
endmodule // sdm_data_mem_tb
